// ### common/cpgc_params.svh
`ifndef CPGC_PARAMS_SVH
`define CPGC_PARAMS_SVH
`define CPGC_A_GEN       8'h10
`define CPGC_A_CRC       8'h11
`define CPGC_A_CHK       8'h12
`define CPGC_A_IPG       8'h13
`define CPGC_A_LC_LO     8'h17
`define CPGC_A_LC_HI     8'h18
`define CPGC_A_INT_ST    8'h1A
`define CPGC_A_INT_MSK   8'h1B
`define CPGC_BURST_HI    15
`define CPGC_BURST_LO    8
`define CPGC_GEN_TRIG    7
`define CPGC_GEN_SELFCLR 6
`define CPGC_GEN_CRCEN   4
`define CPGC_GEN_GENEN   3
`define CPGC_GEN_PAY     2
`define CPGC_GEN_LEN     1
`define CPGC_GEN_ERR     0
`define CPGC_CHK_CNTRST  4
`define CPGC_CHK_STUB    3
`define CPGC_IPG_RST     8'h0C
`define CPGC_LEN_LONG    11'd1518
`define CPGC_LEN_SHORT   11'd64
`define CPGC_FCS_LEN     11'd4
`define CPGC_PRE_LAST    11'd7
`define CPGC_PRE_BYTE    8'h55
`define CPGC_SFD_BYTE    8'hD5
`define CPGC_PAT_A       8'h5A
`define CPGC_PAT_B       8'hA5
`define CPGC_LFSR_SEED   8'h01
`define CPGC_LFSR_TAP    8'h1D
`define CPGC_CRC_POLY    32'hEDB8_8320
`define CPGC_CRC_INIT    32'hFFFF_FFFF
`define CPGC_CRC_RES     32'hDEBB_20E3
`define CPGC_CNT_MAX     8'hFF
`define CPGC_LC_B1       11'd64
`define CPGC_LC_B2       11'd96
`define CPGC_LC_B3       11'd128
`define CPGC_LC_B4       11'd192
`define CPGC_EV_DONE     0
`define CPGC_EV_CRC      1
`define CPGC_EV_LC       2
`endif

// ### common/cpgc_pkg.sv
`include "cpgc_params.svh"
package cpgc_pkg;
    typedef enum logic [1:0] {
        CPGC_IDLE = 2'b00,
        CPGC_PRE  = 2'b01,
        CPGC_DATA = 2'b10,
        CPGC_GAP  = 2'b11
    } cpgc_gen_st_t;

    typedef struct packed {
        logic       en;
        logic       er;
        logic [7:0] d;
    } cpgc_gmii_t;

    typedef struct packed {
        cpgc_gen_st_t    st;
        logic [7:0]      burst;
        logic            done;
        logic            selfclr;
        logic            crc_en;
        logic            gen_en;
        logic            pay;
        logic            len;
        logic            err;
        logic            stub;
        logic [7:0]      ipg;
        logic [7:0]      left;
        logic [10:0]     bcnt;
        logic [7:0]      lfsr;
        logic [31:0]     tcrc;
        logic [31:0]     rcrc;
        logic            rx_in;
        logic            rx_bad;
        logic            rx_dv_d;
        logic [7:0]      rx_pkt;
        logic [7:0]      rx_err;
        logic [3:0][7:0] lc;
        logic [2:0]      ist;
        logic [2:0]      imsk;
        cpgc_gmii_t      tx;
        logic [15:0]     rdata;
        logic            irq;
    } cpgc_state_t;

    localparam cpgc_state_t CPGC_RST_STATE = '{
        st:      CPGC_IDLE,
        ipg:     `CPGC_IPG_RST,
        lfsr:    `CPGC_LFSR_SEED,
        default: '0
    };
endpackage : cpgc_pkg

// ### hdl/cpgc_top.sv
// Function
// - Burst zero sends continuously, else exactly the burst count per trigger.
// - Trigger acts only with self-clear control, enable and nonzero burst all set.
// - Trigger reads one when burst is done, zero while sending.
// - Writing zero to a trigger reading one starts another burst.
// - Trigger writes are ignored while a burst is in progress.
// - Self-clear control zero: enable clears after the last packet.
// - Self-clear control one: enable stays set after the burst.
// - Payload select: zero pseudo-random, one alternating 5A/A5 bytes.
// - Length select: one gives 1518-byte packets, zero gives 64-byte packets.
// - Errored bit adds bad CRC and symbol error to every packet.
// - Received packets counted in saturating 8 bits while checker enabled.
// - CRC-errored packets counted in saturating 8 bits while checker enabled.
// - Counter reset bit clears both checker counters and self-clears.
// - Stub test bit enables stub test mode; clear gives normal operation.
// - Inter-packet gap is programmed value plus one bytes, reset twelve.
// - Half duplex receive start bins collisions at bytes 65-96, 97-128, 129-192.
// - Half duplex receive start after byte 192 bumps fourth counter.
// - Late collision counters saturate and clear on read.
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "cpgc_params.svh"

module cpgc_top (
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic        ce,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output var  logic [15:0] reg_rdata,
    input  wire logic        rx_dv,
    input  wire logic        rx_er,
    input  wire logic [7:0]  rxd,
    input  wire logic        half_duplex,
    output var  logic        tx_en,
    output var  logic        tx_er,
    output var  logic [7:0]  txd,
    output var  logic        stub_test_en,
    output var  logic        irq
);

    cpgc_pkg::cpgc_state_t r;
    cpgc_pkg::cpgc_state_t n;

    logic        wr_gen;
    logic        wr_chk;
    logic        rd_lo;
    logic        rd_hi;
    logic        cnt_clr;
    logic        trig_ok;
    logic        sop;
    logic        gap_end;
    logic        last_pkt;
    logic [10:0] plen;
    logic [10:0] bnum;
    logic [7:0]  pb;
    logic [1:0]  fidx;
    logic [31:0] fcs;
    logic [2:0]  ev;

    function automatic logic [31:0] cpgc_crc(input logic [31:0] c,
                                             input logic [7:0]  d);
        logic [31:0] x;
        x = c;
        for (int i = 0; i < 8; i++) begin
            x = {1'b0, x[31:1]} ^ ({32{x[0] ^ d[i]}} & `CPGC_CRC_POLY);
        end
        return x;
    endfunction : cpgc_crc

    function automatic logic [7:0] cpgc_sat(input logic [7:0] v);
        return (v == `CPGC_CNT_MAX) ? v : v + 8'h01;
    endfunction : cpgc_sat

    assign wr_gen   = reg_wr && (reg_addr == `CPGC_A_GEN);
    assign wr_chk   = reg_wr && (reg_addr == `CPGC_A_CHK);
    assign rd_lo    = reg_rd && (reg_addr == `CPGC_A_LC_LO);
    assign rd_hi    = reg_rd && (reg_addr == `CPGC_A_LC_HI);
    assign cnt_clr  = wr_chk && reg_wdata[`CPGC_CHK_CNTRST];
    assign sop      = rx_dv && !r.rx_dv_d;
    assign plen     = r.len ? `CPGC_LEN_LONG : `CPGC_LEN_SHORT;
    assign bnum     = r.bcnt;
    assign gap_end  = (r.st == cpgc_pkg::CPGC_GAP) && (r.bcnt == 11'd0);
    assign last_pkt = (r.burst != 8'h00) && (r.left <= 8'h01);
    assign fidx     = 2'(r.bcnt - (plen - `CPGC_FCS_LEN));
    // A bad FCS is sent uninverted so it can never match by accident
    assign fcs      = r.err ? r.tcrc : ~r.tcrc;

    // Trigger is only honoured with the written control bits all valid
    assign trig_ok  = wr_gen && r.done && !reg_wdata[`CPGC_GEN_TRIG]
                      && reg_wdata[`CPGC_GEN_SELFCLR]
                      && reg_wdata[`CPGC_GEN_GENEN]
                      && (reg_wdata[`CPGC_BURST_HI:`CPGC_BURST_LO] != 8'h00);

    always_comb begin
        n         = r;
        n.tx      = '0;
        n.rdata   = 16'h0000;
        n.rx_dv_d = rx_dv;
        ev        = 3'b000;
        pb        = r.pay ? (r.bcnt[0] ? `CPGC_PAT_B : `CPGC_PAT_A) : r.lfsr;

        if (wr_gen) begin
            n.burst   = reg_wdata[`CPGC_BURST_HI:`CPGC_BURST_LO];
            n.selfclr = reg_wdata[`CPGC_GEN_SELFCLR];
            n.crc_en  = reg_wdata[`CPGC_GEN_CRCEN];
            n.gen_en  = reg_wdata[`CPGC_GEN_GENEN];
            n.pay     = reg_wdata[`CPGC_GEN_PAY];
            n.len     = reg_wdata[`CPGC_GEN_LEN];
            n.err     = reg_wdata[`CPGC_GEN_ERR];
            // Trigger bit itself is never stored; writes while busy fall here
            if (trig_ok || (reg_wdata[`CPGC_GEN_GENEN] && !r.gen_en)) begin
                n.done = 1'b0;
                n.left = reg_wdata[`CPGC_BURST_HI:`CPGC_BURST_LO];
                if (r.st == cpgc_pkg::CPGC_IDLE) begin
                    n.st   = cpgc_pkg::CPGC_PRE;
                    n.bcnt = 11'd0;
                end
            end
        end
        if (wr_chk) begin
            n.stub = reg_wdata[`CPGC_CHK_STUB];
        end
        if (reg_wr && (reg_addr == `CPGC_A_IPG)) begin
            n.ipg = reg_wdata[7:0];
        end
        if (reg_wr && (reg_addr == `CPGC_A_INT_MSK)) begin
            n.imsk = reg_wdata[2:0];
        end

        unique case (r.st)
            cpgc_pkg::CPGC_IDLE: begin
            end
            cpgc_pkg::CPGC_PRE: begin
                n.tx.en = 1'b1;
                n.tx.d  = (r.bcnt == `CPGC_PRE_LAST) ? `CPGC_SFD_BYTE : `CPGC_PRE_BYTE;
                n.bcnt  = r.bcnt + 11'd1;
                if (r.bcnt == `CPGC_PRE_LAST) begin
                    n.st   = cpgc_pkg::CPGC_DATA;
                    n.bcnt = 11'd0;
                    n.tcrc = `CPGC_CRC_INIT;
                end
            end
            cpgc_pkg::CPGC_DATA: begin
                n.tx.en = 1'b1;
                n.bcnt  = r.bcnt + 11'd1;
                if (r.bcnt < plen - `CPGC_FCS_LEN) begin
                    n.tx.d = pb;
                    n.tcrc = cpgc_crc(r.tcrc, pb);
                    if (!r.pay) begin
                        n.lfsr = {r.lfsr[6:0], 1'b0}
                                 ^ (r.lfsr[7] ? `CPGC_LFSR_TAP : 8'h00);
                    end
                end else begin
                    n.tx.d = 8'(fcs >> {fidx, 3'b000});
                end
                // Symbol error rides on the first data byte
                n.tx.er = r.err && (r.bcnt == 11'd0);
                if (r.bcnt == plen - 11'd1) begin
                    n.st   = cpgc_pkg::CPGC_GAP;
                    n.bcnt = {3'b000, r.ipg};
                end
            end
            cpgc_pkg::CPGC_GAP: begin
                if (r.bcnt != 11'd0) begin
                    n.bcnt = r.bcnt - 11'd1;
                end else begin
                    if (r.burst != 8'h00) begin
                        n.left = r.left - 8'h01;
                    end
                    if (last_pkt) begin
                        n.st   = cpgc_pkg::CPGC_IDLE;
                        n.done = 1'b1;
                        ev[`CPGC_EV_DONE] = 1'b1;
                        if (!r.selfclr) begin
                            n.gen_en = 1'b0;
                        end
                    end else if (r.gen_en) begin
                        n.st   = cpgc_pkg::CPGC_PRE;
                        n.bcnt = 11'd0;
                    end else begin
                        n.st   = cpgc_pkg::CPGC_IDLE;
                        n.done = 1'b1;
                        ev[`CPGC_EV_DONE] = 1'b1;
                    end
                end
            end
        endcase

        // Clear first so a same-cycle frame end still counts
        if (cnt_clr) begin
            n.rx_pkt = 8'h00;
            n.rx_err = 8'h00;
        end
        if (rx_dv && !r.rx_in && (rxd == `CPGC_SFD_BYTE)) begin
            n.rx_in  = 1'b1;
            n.rx_bad = 1'b0;
            n.rcrc   = `CPGC_CRC_INIT;
        end
        if (r.rx_in && rx_dv) begin
            n.rcrc   = cpgc_crc(r.rcrc, rxd);
            n.rx_bad = r.rx_bad || rx_er;
        end
        if (r.rx_in && !rx_dv) begin
            n.rx_in = 1'b0;
            if (r.crc_en) begin
                n.rx_pkt = cpgc_sat(n.rx_pkt);
                if (r.rx_bad || (r.rcrc != `CPGC_CRC_RES)) begin
                    n.rx_err = cpgc_sat(n.rx_err);
                    ev[`CPGC_EV_CRC] = 1'b1;
                end
            end
        end

        if (reg_rd) begin
            unique case (reg_addr)
                `CPGC_A_GEN:     n.rdata = {r.burst, r.done, r.selfclr, 1'b0, r.crc_en,
                                            r.gen_en, r.pay, r.len, r.err};
                `CPGC_A_CRC:     n.rdata = {r.rx_pkt, r.rx_err};
                `CPGC_A_CHK:     n.rdata = {12'h000, r.stub, 3'b000};
                `CPGC_A_IPG:     n.rdata = {8'h00, r.ipg};
                `CPGC_A_LC_LO:   n.rdata = {r.lc[1], r.lc[0]};
                `CPGC_A_LC_HI:   n.rdata = {r.lc[3], r.lc[2]};
                `CPGC_A_INT_ST:  n.rdata = {13'h0000, r.ist};
                `CPGC_A_INT_MSK: n.rdata = {13'h0000, r.imsk};
                default:         n.rdata = 16'h0000;
            endcase
        end
        if (rd_lo) begin
            n.lc[0] = 8'h00;
            n.lc[1] = 8'h00;
        end
        if (rd_hi) begin
            n.lc[2] = 8'h00;
            n.lc[3] = 8'h00;
        end
        // Collision binned on the byte now standing on txd
        if (sop && half_duplex && (r.st == cpgc_pkg::CPGC_DATA)) begin
            for (int k = 0; k < 4; k++) begin
                if ((k == 3 && bnum > `CPGC_LC_B4)
                    || (k == 2 && bnum > `CPGC_LC_B3 && bnum <= `CPGC_LC_B4)
                    || (k == 1 && bnum > `CPGC_LC_B2 && bnum <= `CPGC_LC_B3)
                    || (k == 0 && bnum > `CPGC_LC_B1 && bnum <= `CPGC_LC_B2)) begin
                    n.lc[k] = cpgc_sat(n.lc[k]);
                    ev[`CPGC_EV_LC] = 1'b1;
                end
            end
        end

        // Sticky events win over a same-cycle write-one clear
        if (reg_wr && (reg_addr == `CPGC_A_INT_ST)) begin
            n.ist = r.ist & ~reg_wdata[2:0];
        end
        n.ist = n.ist | ev;
        n.irq = |(n.ist & n.imsk);
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            r <= cpgc_pkg::CPGC_RST_STATE;
        end else if (ce) begin
            r <= n;
        end
    end

    assign reg_rdata    = r.rdata;
    assign tx_en        = r.tx.en;
    assign tx_er        = r.tx.er;
    assign txd          = r.tx.d;
    assign stub_test_en = r.stub;
    assign irq          = r.irq;

    property p_burst_end;
        @(posedge core_clk) disable iff (!nrst)
        (ce && gap_end && last_pkt) |=> (r.st == cpgc_pkg::CPGC_IDLE) && r.done;
    endproperty
    a_burst_end: assert property (p_burst_end) else $error("burst did not stop");

    property p_cont;
        @(posedge core_clk) disable iff (!nrst)
        (ce && gap_end && r.burst == 8'h00 && r.gen_en && !wr_gen)
        |=> r.st == cpgc_pkg::CPGC_PRE;
    endproperty
    a_cont: assert property (p_cont) else $error("continuous mode stopped");

    property p_busy;
        @(posedge core_clk) disable iff (!nrst)
        (r.st != cpgc_pkg::CPGC_IDLE) |-> !r.done;
    endproperty
    a_busy: assert property (p_busy) else $error("done shown while sending");

    property p_retrig;
        @(posedge core_clk) disable iff (!nrst)
        (ce && trig_ok && r.st == cpgc_pkg::CPGC_IDLE)
        |=> !r.done ##1 (!ce || r.st == cpgc_pkg::CPGC_PRE);
    endproperty
    a_retrig: assert property (p_retrig) else $error("trigger did not restart");

    property p_ignore;
        @(posedge core_clk) disable iff (!nrst)
        (ce && !r.done && wr_gen && !gap_end) |=> !r.done;
    endproperty
    a_ignore: assert property (p_ignore) else $error("busy trigger write acted");

    property p_selfclr;
        @(posedge core_clk) disable iff (!nrst)
        (ce && gap_end && last_pkt && r.gen_en && !wr_gen) |=> (r.gen_en == $past(r.selfclr));
    endproperty
    a_selfclr: assert property (p_selfclr) else $error("enable self-clear wrong");

    property p_pattern;
        @(posedge core_clk) disable iff (!nrst)
        (ce && r.st == cpgc_pkg::CPGC_DATA && r.pay && r.bcnt == 11'd1)
        |=> txd == `CPGC_PAT_B;
    endproperty
    a_pattern: assert property (p_pattern) else $error("pattern byte wrong");

    property p_gap;
        @(posedge core_clk) disable iff (!nrst)
        (ce && r.st == cpgc_pkg::CPGC_DATA && r.bcnt == plen - 11'd1)
        |=> (r.st == cpgc_pkg::CPGC_GAP) && (r.bcnt == {3'b000, r.ipg}) ##1 !tx_en;
    endproperty
    a_gap: assert property (p_gap) else $error("packet end or gap wrong");

    property p_sat;
        @(posedge core_clk) disable iff (!nrst)
        (r.rx_pkt == `CPGC_CNT_MAX && !cnt_clr) |=> r.rx_pkt == `CPGC_CNT_MAX;
    endproperty
    a_sat: assert property (p_sat) else $error("packet counter wrapped");

    property p_cntrst;
        @(posedge core_clk) disable iff (!nrst)
        (ce && cnt_clr) |=> (r.rx_pkt <= 8'h01) && (r.rx_err <= 8'h01);
    endproperty
    a_cntrst: assert property (p_cntrst) else $error("counters not cleared");

    property p_lc4;
        @(posedge core_clk) disable iff (!nrst)
        (ce && sop && half_duplex && r.st == cpgc_pkg::CPGC_DATA && bnum > `CPGC_LC_B4
         && r.lc[3] != `CPGC_CNT_MAX && !rd_hi) |=> r.lc[3] == $past(r.lc[3]) + 8'h01;
    endproperty
    a_lc4: assert property (p_lc4) else $error("late collision not counted");

    property p_lcrc;
        @(posedge core_clk) disable iff (!nrst)
        (ce && rd_lo && !sop) |=> (r.lc[0] == 8'h00) && (r.lc[1] == 8'h00);
    endproperty
    a_lcrc: assert property (p_lcrc) else $error("counter not cleared on read");

    c_burst: cover property (@(posedge core_clk) disable iff (!nrst) ce && gap_end && last_pkt);
    c_crc: cover property (@(posedge core_clk) disable iff (!nrst) ce && ev[`CPGC_EV_CRC]);
    c_lc: cover property (@(posedge core_clk) disable iff (!nrst) ce && ev[`CPGC_EV_LC]);

endmodule : cpgc_top
`default_nettype wire

// ### tb/cpgc_link_partner.sv
`timescale 1ns/1ps
`default_nettype none
module cpgc_link_partner (
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic        loop_en,
    input  wire logic [10:0] coll_at,
    input  wire logic        tx_en,
    input  wire logic        tx_er,
    input  wire logic [7:0]  txd,
    output var  logic        rx_dv,
    output var  logic        rx_er,
    output var  logic [7:0]  rxd
);
    logic [10:0] n_r;
    logic [10:0] n_nxt;
    logic        coll;

    // Number of the data byte txd shows next cycle, 1 = first after the delimiter
    always_comb begin
        n_nxt = 11'h000;
        if (tx_en && n_r != 11'h000)
            n_nxt = n_r + 11'h001;
        else if (tx_en && txd == 8'hD5)
            n_nxt = 11'h001;
        coll = coll_at != 11'h000 && n_nxt >= coll_at && n_nxt < coll_at + 11'h004;
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            n_r   <= 11'h000;
            rx_dv <= 1'b0;
            rx_er <= 1'b0;
            rxd   <= 8'h00;
        end else begin
            n_r   <= n_nxt;
            rx_dv <= loop_en ? tx_en : coll;
            rx_er <= loop_en & tx_er;
            // Idle data toggles so a stale byte is never mistaken for a frame
            rxd   <= (loop_en && tx_en) ? txd : (coll ? 8'h00 : ~rxd);
        end
    end
endmodule : cpgc_link_partner
`default_nettype wire

// ### tb/cpgc_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpgc_params.svh"
module cpgc_top_bench;
    logic        core_clk    = 1'b0;
    logic        nrst        = 1'b0;
    logic        ce          = 1'b1;
    logic [7:0]  reg_addr    = 8'h00;
    logic [15:0] reg_wdata   = 16'h0000;
    logic        reg_wr      = 1'b0;
    logic        reg_rd      = 1'b0;
    logic        half_duplex = 1'b0;
    logic        loop_en     = 1'b1;
    logic [10:0] coll_at     = 11'h000;
    logic [15:0] reg_rdata;
    logic        rx_dv, rx_er, tx_en, tx_er, stub_test_en, irq;
    logic [7:0]  rxd, txd;
    logic [15:0] rv;
    logic        chk_pat     = 1'b0;
    logic        was_en      = 1'b0;
    int          n_mismatch  = 0;
    int          n_checks    = 0;
    int          nfr = 0, flen = 0, gap = 0, last_len = 0, last_gap = 0;
    int          n_fmtbad = 0, n_txer = 0, exp_len = 64, n0 = 0;
    logic [15:0] noop [2]    = '{16'h005B, 16'h021B};
    logic [10:0] coll_tbl [4] = '{11'h060, 11'h080, 11'h0C0, 11'h0C1};

    always #5 core_clk = ~core_clk;

    cpgc_top dut_u (.core_clk(core_clk), .nrst(nrst), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rx_dv(rx_dv), .rx_er(rx_er), .rxd(rxd), .half_duplex(half_duplex),
        .tx_en(tx_en), .tx_er(tx_er), .txd(txd), .stub_test_en(stub_test_en), .irq(irq));

    cpgc_link_partner partner_u (.core_clk(core_clk), .nrst(nrst), .loop_en(loop_en),
        .coll_at(coll_at), .tx_en(tx_en), .tx_er(tx_er), .txd(txd), .rx_dv(rx_dv),
        .rx_er(rx_er), .rxd(rxd));

    // Frame monitor: length, gap, preamble and fixed payload pattern
    always @(posedge core_clk) begin
        if (tx_en === 1'b1) begin
            if ((flen < 7 && txd !== `CPGC_PRE_BYTE) || (flen == 7 && txd !== `CPGC_SFD_BYTE))
                n_fmtbad++;
            if (chk_pat && flen >= 8 && flen < exp_len + 4 &&
                txd !== ((flen % 2 == 0) ? `CPGC_PAT_A : `CPGC_PAT_B))
                n_fmtbad++;
            if (!was_en)
                last_gap = gap;
            flen++;
        end else begin
            if (was_en) begin
                nfr++;
                last_len = flen;
                flen = 0;
                gap = 0;
            end
            gap++;
        end
        if (tx_er === 1'b1)
            n_txer++;
        was_en = (tx_en === 1'b1);
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        rd(a, d);
        check($sformatf("register %h", a), d, exp);
    endtask : rdchk

    task automatic wait_done;
        int i;
        rv = 16'h0000;
        for (i = 0; i < 20000 && rv[`CPGC_GEN_TRIG] !== 1'b1; i++)
            rd(`CPGC_A_GEN, rv);
        check("done flag", {15'h0000, rv[`CPGC_GEN_TRIG]}, 16'h0001);
    endtask : wait_done

    task automatic wait_frames(input int n);
        int i;
        for (i = 0; i < 40000 && nfr < n; i++)
            @(posedge core_clk);
    endtask : wait_frames

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish

    initial begin
        #1_000_000;
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        rdchk(`CPGC_A_GEN, 16'h0000);
        rdchk(`CPGC_A_CRC, 16'h0000);
        rdchk(`CPGC_A_CHK, 16'h0000);
        rdchk(`CPGC_A_IPG, 16'h000C);
        rdchk(`CPGC_A_LC_LO, 16'h0000);
        rdchk(`CPGC_A_LC_HI, 16'h0000);
        rdchk(8'h05, 16'h0000);
        // Short burst of three, fixed pattern, enable clears at the end
        wr(`CPGC_A_IPG, 16'h0003);
        chk_pat = 1'b1;
        wr(`CPGC_A_GEN, 16'h031C);
        rdchk(`CPGC_A_GEN, 16'h031C);
        wait_done();
        check("frames", nfr, 3);
        check("frame length", last_len, 72);
        check("gap", last_gap, 4);
        check("format", n_fmtbad, 0);
        rdchk(`CPGC_A_GEN, 16'h0394);
        rdchk(`CPGC_A_CRC, 16'h0300);
        check("irq masked", irq, 1'b0);
        wr(`CPGC_A_INT_MSK, 16'h0001);
        repeat (2) @(posedge core_clk);
        check("irq", irq, 1'b1);
        rdchk(`CPGC_A_INT_ST, 16'h0001);
        wr(`CPGC_A_INT_ST, 16'h0001);
        repeat (2) @(posedge core_clk);
        check("irq cleared", irq, 1'b0);
        // Long errored burst kept enabled; a busy trigger write must not restart it
        chk_pat = 1'b0;
        exp_len = 1518;
        nfr = 0;
        n_txer = 0;
        wr(`CPGC_A_GEN, 16'h025B);
        wait_frames(1);
        wr(`CPGC_A_GEN, 16'h025B);
        wait_done();
        check("frames", nfr, 2);
        check("frame length", last_len, 1526);
        check("symbol errors", n_txer, 2);
        rdchk(`CPGC_A_GEN, 16'h02DB);
        rdchk(`CPGC_A_CRC, 16'h0502);
        nfr = 0;
        wr(`CPGC_A_GEN, 16'h025B);
        wait_done();
        check("frames", nfr, 2);
        // Trigger writes that lack a nonzero burst or the self-clear bit
        foreach (noop[i]) begin
            nfr = 0;
            wr(`CPGC_A_GEN, noop[i]);
            repeat (300) @(posedge core_clk);
            check("frames", nfr, 0);
        end
        wr(`CPGC_A_GEN, 16'h0000);
        wr(`CPGC_A_CHK, 16'h0010);
        rdchk(`CPGC_A_CRC, 16'h0000);
        rdchk(`CPGC_A_CHK, 16'h0000);
        wr(`CPGC_A_GEN, 16'h020C);
        wait_done();
        rdchk(`CPGC_A_CRC, 16'h0000);
        // Continuous run well past the counter limit
        chk_pat = 1'b1;
        exp_len = 64;
        nfr = 0;
        wr(`CPGC_A_GEN, 16'h001C);
        wait_frames(260);
        // Payload select kept so a frame in progress at the stop write keeps the pattern
        wr(`CPGC_A_GEN, 16'h0014);
        repeat (200) @(posedge core_clk);
        n0 = nfr;
        check("continuous", {15'h0000, nfr >= 260}, 16'h0001);
        rdchk(`CPGC_A_CRC, 16'hFF00);
        repeat (200) @(posedge core_clk);
        check("stopped", nfr, n0);
        check("format", n_fmtbad, 0);
        wr(`CPGC_A_CHK, 16'h0008);
        repeat (2) @(posedge core_clk);
        check("stub", stub_test_en, 1'b1);
        rdchk(`CPGC_A_CHK, 16'h0008);
        wr(`CPGC_A_CHK, 16'h0000);
        repeat (2) @(posedge core_clk);
        check("stub", stub_test_en, 1'b0);
        // One long frame per collision bin, partner starts mid-frame
        loop_en <= 1'b0;
        half_duplex <= 1'b1;
        foreach (coll_tbl[i]) begin
            coll_at <= coll_tbl[i];
            wr(`CPGC_A_GEN, 16'h010A);
            wait_done();
        end
        rdchk(`CPGC_A_LC_LO, 16'h0101);
        rdchk(`CPGC_A_LC_HI, 16'h0101);
        rdchk(`CPGC_A_LC_LO, 16'h0000);
        rdchk(`CPGC_A_LC_HI, 16'h0000);
        tally_and_finish();
    end
endmodule : cpgc_top_bench
`default_nettype wire
